/* pkg/clock_source_control_pkg.sv */
// constants for the clock source control block
package clock_source_control_pkg;
   // register byte addresses
   localparam logic [19:0] ADDR_MODE = 20'hfffa0;
   localparam logic [19:0] ADDR_RUN = 20'hfffa4;
   localparam logic [19:0] ADDR_SYSCLK = 20'hfffa8;
   localparam logic [19:0] ADDR_FAST = 20'hfffac;
   localparam logic [19:0] ADDR_STATUS = 20'hfffb0;
   // reset values
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] RUN_RESET = 8'hc0;
   localparam logic [7:0] SYSCLK_RESET = 8'h09;
   localparam logic [7:0] FAST_RESET = 8'h00;
   // mode register fields
   localparam int MODE_EXT_CLK_BIT = 7;
   localparam int MODE_MAIN_PIN_BIT = 6;
   localparam int MODE_SUB_PIN_BIT = 4;
   localparam int MODE_DRIVE_HI_BIT = 2;
   localparam int MODE_DRIVE_LO_BIT = 1;
   localparam int MODE_RANGE_BIT = 0;
   localparam logic [7:0] MODE_WRITABLE = 8'hd7;
   // run status control fields (1 = oscillator stopped)
   localparam int RUN_MAIN_STOP_BIT = 7;
   localparam int RUN_SUB_STOP_BIT = 6;
   // fast internal oscillator control fields
   localparam int FAST_ENABLE_BIT = 0;
   localparam int FAST_SELECT_BIT = 1;
   // status register fields
   localparam int STAT_MODE_LOCKED_BIT = 0;
   localparam int STAT_CPU_RUN_BIT = 1;
   localparam int STAT_FAST_READY_BIT = 2;
   localparam int STAT_FAST_AVAIL_BIT = 3;
   localparam int STAT_MAIN_RUN_BIT = 4;
   localparam int STAT_SUB_RUN_BIT = 5;
   localparam int STAT_FAST_SEL_BIT = 6;
   // pin mode encodings of the main pin pair
   localparam logic [1:0] MAIN_PINS_PORT = 2'h0;
   localparam logic [1:0] MAIN_PINS_RESONATOR = 2'h1;
   localparam logic [1:0] MAIN_PINS_PORT_ALT = 2'h2;
   localparam logic [1:0] MAIN_PINS_EXT_CLOCK = 2'h3;
   // sub drive encodings
   localparam logic [1:0] SUB_DRIVE_LOW_POWER = 2'h0;
   localparam logic [1:0] SUB_DRIVE_NORMAL = 2'h1;
   localparam logic [1:0] SUB_DRIVE_ULTRA_LOW = 2'h2;
   // internal oscillator frequency option encodings
   localparam logic [1:0] FREQ_OPT_1MHZ = 2'h0;
   // timing
   localparam int CLOCK_PERIOD_PS = 5000;
   localparam int SETTLE_TIME_NS = 1000;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
   localparam int FAST_WAIT_US = 100;
   localparam int FAST_WAIT_CYCLES =
      (FAST_WAIT_US * 1000000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
   // reset processing sequence
   typedef enum logic [1:0] {
      SEQ_HOLD = 2'b00,
      SEQ_SETTLE = 2'b01,
      SEQ_RUN = 2'b11
   } seq_state_e;
endpackage : clock_source_control_pkg

/* src/cycle_timer.sv */
// counter that flags when a start level has stood for a set number of cycles
`timescale 1ns/100ps
module cycle_timer #(
   parameter int CYCLES = 200,
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // control
   input wire logic start,
   output logic done
);
   localparam logic [WIDTH-1:0] LAST = WIDTH'(CYCLES - 1);
   logic [WIDTH-1:0] count;
   wire atLast = (count == LAST);

   // dropping start restarts the wait from zero
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
         done <= 1'b0;
      end else if (!start) begin
         count <= '0;
         done <= 1'b0;
      end else if (!done) begin
         count <= atLast ? count : count + 1'b1;
         done <= atLast;
      end
   end
endmodule : cycle_timer

/* src/clock_source_control.sv */
// clock source mode register, start-up sequencing and oscillator controls
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - main pin pair mode from two bits
// - sub pins: port or crystal, bit 4
// - sub drive: low, normal, ultra-low power
// - range bit picks 2-10 or 10-20 MHz
// - mode register written once, full byte
// - power-on clear holds, then oscillator starts
// - cpu runs after reset processing settles
// - system clock control resets to 09H
// - no fast oscillator with 1 MHz option
// - detector holds reset until 2.07 V
module clock_source_control #(
   parameter int FAST_WAIT = clock_source_control_pkg::FAST_WAIT_CYCLES,
   parameter int SETTLE_WAIT = clock_source_control_pkg::SETTLE_CYCLES,
   parameter bit HAS_SUB_PINS = 1'b1
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [19:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // supply monitors and option straps (asynchronous)
   input wire logic supplyAboveClear,
   input wire logic supplyAboveDetect,
   input wire logic detectorDefaultOn,
   input wire logic [1:0] intFreqOption,
   // pin and oscillator controls
   output logic [1:0] mainPinMode,
   output logic mainPinsArePorts,
   output logic mainOscRun,
   output logic extClockInputSel,
   output logic mainFreqRange,
   output logic subOscPinSel,
   output logic subOscRun,
   output logic [1:0] subDriveMode,
   // clock generator state
   output logic internalReset,
   output logic internalFastClockRun,
   output logic cpuRun,
   output logic [7:0] systemClockCtrl,
   output logic fastIntOscEnable,
   output logic fastIntOscSelect
);
   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [4:0] syncA;
   logic [4:0] syncB;
   wire [4:0] rawIn = {intFreqOption, detectorDefaultOn, supplyAboveDetect, supplyAboveClear};

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         syncA <= 5'h00;
         syncB <= 5'h00;
      end else begin
         syncA <= rawIn;
         syncB <= syncA;
      end
   end

   wire supplyOk = syncB[0];
   wire detectOk = syncB[1];
   wire detectOn = syncB[2];
   wire [1:0] freqOpt = syncB[4:3];
   wire fastAvailable = (freqOpt != clock_source_control_pkg::FREQ_OPT_1MHZ);

   ////////////////////////////////////////////////////////////////////////////
   // reset processing sequence
   clock_source_control_pkg::seq_state_e seqState;
   clock_source_control_pkg::seq_state_e next_seqState;
   logic settleDone;

   // power-on clear, and the detector when it is on by default
   wire holdReset = !supplyOk || (detectOn && !detectOk);

   always_comb begin
      next_seqState = seqState;
      case (seqState)
         clock_source_control_pkg::SEQ_HOLD:
            next_seqState = clock_source_control_pkg::SEQ_SETTLE;
         clock_source_control_pkg::SEQ_SETTLE:
            if (settleDone) next_seqState = clock_source_control_pkg::SEQ_RUN;
         clock_source_control_pkg::SEQ_RUN:
            next_seqState = clock_source_control_pkg::SEQ_RUN;
         default:
            next_seqState = clock_source_control_pkg::SEQ_HOLD;
      endcase
      if (holdReset) next_seqState = clock_source_control_pkg::SEQ_HOLD;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) seqState <= clock_source_control_pkg::SEQ_HOLD;
      else seqState <= next_seqState;
   end

   cycle_timer #(
      .CYCLES(SETTLE_WAIT),
      .WIDTH(16)
   ) settleTimer (
      .clock(clock),
      .reset_n(reset_n),
      .start(seqState == clock_source_control_pkg::SEQ_SETTLE),
      .done(settleDone)
   );

   // the internal oscillator starts as soon as the hold lifts, with no software
   wire inHold = (seqState == clock_source_control_pkg::SEQ_HOLD);
   assign internalReset = inHold;
   assign internalFastClockRun = !inHold;
   assign cpuRun = (seqState == clock_source_control_pkg::SEQ_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire access = psel && penable;
   wire hitMode = (paddr == clock_source_control_pkg::ADDR_MODE);
   wire hitRun = (paddr == clock_source_control_pkg::ADDR_RUN);
   wire hitSys = (paddr == clock_source_control_pkg::ADDR_SYSCLK);
   wire hitFast = (paddr == clock_source_control_pkg::ADDR_FAST);
   wire hitStat = (paddr == clock_source_control_pkg::ADDR_STATUS);
   wire mapped = hitMode || hitRun || hitSys || hitFast || hitStat;
   wire doWrite = access && pwrite && mapped && pstrb[0];
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   logic [7:0] modeReg;
   logic modeLocked;
   logic [7:0] runReg;
   logic [7:0] sysReg;
   logic [7:0] fastReg;
   logic fastReady;

   // only a full byte write counts, and only the first one after reset
   wire fullByte = (pstrb == 4'hf) || (pstrb == 4'h1);
   wire modeWrite = doWrite && hitMode && fullByte && !modeLocked;
   wire [7:0] subMask = HAS_SUB_PINS ? 8'hff : 8'hef;
   wire [7:0] modeNext = pwdata[7:0] & clock_source_control_pkg::MODE_WRITABLE & subMask;

   ////////////////////////////////////////////////////////////////////////////
   // registers; the internal reset puts them all back to their reset values
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         modeReg <= clock_source_control_pkg::MODE_RESET;
         modeLocked <= 1'b0;
      end else if (inHold) begin
         modeReg <= clock_source_control_pkg::MODE_RESET;
         modeLocked <= 1'b0;
      end else if (modeWrite) begin
         modeReg <= modeNext;
         modeLocked <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         runReg <= clock_source_control_pkg::RUN_RESET;
         sysReg <= clock_source_control_pkg::SYSCLK_RESET;
         fastReg <= clock_source_control_pkg::FAST_RESET;
      end else if (inHold) begin
         runReg <= clock_source_control_pkg::RUN_RESET;
         sysReg <= clock_source_control_pkg::SYSCLK_RESET;
         fastReg <= clock_source_control_pkg::FAST_RESET;
      end else begin
         if (doWrite && hitRun) runReg <= pwdata[7:0] & 8'hc0;
         if (doWrite && hitSys) sysReg <= pwdata[7:0];
         if (doWrite && hitFast) fastReg <= pwdata[7:0] & 8'h03;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // main and sub oscillator pins
   assign mainPinMode = {modeReg[clock_source_control_pkg::MODE_EXT_CLK_BIT],
                         modeReg[clock_source_control_pkg::MODE_MAIN_PIN_BIT]};
   assign mainPinsArePorts = (mainPinMode == clock_source_control_pkg::MAIN_PINS_PORT) ||
                             (mainPinMode == clock_source_control_pkg::MAIN_PINS_PORT_ALT);
   assign extClockInputSel = (mainPinMode == clock_source_control_pkg::MAIN_PINS_EXT_CLOCK);
   assign mainFreqRange = modeReg[clock_source_control_pkg::MODE_RANGE_BIT];
   assign subOscPinSel = modeReg[clock_source_control_pkg::MODE_SUB_PIN_BIT];
   assign subDriveMode = {modeReg[clock_source_control_pkg::MODE_DRIVE_HI_BIT],
                          modeReg[clock_source_control_pkg::MODE_DRIVE_LO_BIT]};

   // external oscillators never start by themselves: software clears a stop bit
   wire mainStop = runReg[clock_source_control_pkg::RUN_MAIN_STOP_BIT];
   wire subStop = runReg[clock_source_control_pkg::RUN_SUB_STOP_BIT];
   assign mainOscRun = cpuRun && !mainStop &&
                       (mainPinMode == clock_source_control_pkg::MAIN_PINS_RESONATOR);
   assign subOscRun = cpuRun && !subStop && subOscPinSel;
   assign systemClockCtrl = sysReg;

   ////////////////////////////////////////////////////////////////////////////
   // fast internal oscillator: enable, wait, then select
   assign fastIntOscEnable = fastReg[clock_source_control_pkg::FAST_ENABLE_BIT] &&
                             fastAvailable && !inHold;

   cycle_timer #(
      .CYCLES(FAST_WAIT),
      .WIDTH(16)
   ) fastTimer (
      .clock(clock),
      .reset_n(reset_n),
      .start(fastIntOscEnable),
      .done(fastReady)
   );

   // a select before the oscillator is ready is held off, never glitching the cpu clock
   assign fastIntOscSelect = fastReg[clock_source_control_pkg::FAST_SELECT_BIT] &&
                             fastIntOscEnable && fastReady;

   ////////////////////////////////////////////////////////////////////////////
   // read data
   wire [7:0] statusByte = {1'b0,
                            fastIntOscSelect,
                            subOscRun,
                            mainOscRun,
                            fastAvailable,
                            fastReady,
                            cpuRun,
                            modeLocked};
   wire [7:0] readByte = hitMode ? modeReg :
                         hitRun ? runReg :
                         hitSys ? sysReg :
                         hitFast ? fastReg :
                         hitStat ? statusByte : 8'h00;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite) prdata <= {24'h000000, readByte};
   end
endmodule : clock_source_control

/* test/osc_source_model.sv */
// behavioural crystal or external clock source at the oscillator pins
`timescale 1ns/100ps
module osc_source_model #(
   parameter int SETTLE_EDGES = 8
) (
   // run requests from the block
   input wire logic mainRun,
   input wire logic subRun,
   // pin waves and settled flag
   output logic mainWave,
   output logic subWave,
   output logic mainStable
);
   int edges;
   initial begin
      mainWave = 1'b0;
      subWave = 1'b0;
      edges = 0;
   end
   // pins stand still while stopped; a restart has to settle from scratch
   always #25 begin
      mainWave = mainRun && !mainWave;
      edges = mainRun ? edges + 1 : 0;
   end
   always #15000 subWave = subRun && !subWave;
   assign mainStable = edges >= SETTLE_EDGES;
endmodule : osc_source_model

/* test/clock_source_control_sva.sv */
// port assertions for the clock source control block
`timescale 1ns/100ps
module clock_source_control_sva #(
   parameter int FAST_WAIT = 20,
   parameter int SETTLE_WAIT = 200
) (
   // clock, reset and bus
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [19:0] paddr,
   input wire logic [3:0] pstrb,
   // straps and supply
   input wire logic supplyAboveDetect,
   input wire logic detectorDefaultOn,
   input wire logic [1:0] intFreqOption,
   // outputs watched
   input wire logic [1:0] mainPinMode,
   input wire logic mainPinsArePorts,
   input wire logic mainOscRun,
   input wire logic extClockInputSel,
   input wire logic subOscPinSel,
   input wire logic subOscRun,
   input wire logic [1:0] subDriveMode,
   input wire logic internalReset,
   input wire logic internalFastClockRun,
   input wire logic cpuRun,
   input wire logic [7:0] systemClockCtrl,
   input wire logic fastIntOscEnable,
   input wire logic fastIntOscSelect
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   logic locked;
   int fastCount;
   int settleCount;
   wire modeWrite = psel && penable && pwrite && paddr == clock_source_control_pkg::ADDR_MODE
      && (pstrb == 4'hf || pstrb == 4'h1);
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         locked <= 1'b0;
         fastCount <= 0;
         settleCount <= 0;
      end else begin
         locked <= !internalReset && (locked || modeWrite);
         fastCount <= fastIntOscEnable ? fastCount + 1 : 0;
         settleCount <= internalReset ? 0 : settleCount + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   lock_hold_a: assert property (locked && modeWrite |=> $stable(mainPinMode))
      else $error("mode register changed after lock");
   ext_sel_a: assert property (extClockInputSel == (mainPinMode == 2'h3))
      else $error("external clock select wrong");
   pin_ports_a: assert property (mainPinsArePorts == !mainPinMode[0])
      else $error("port mode of main pins wrong");
   main_run_a: assert property (mainOscRun |-> mainPinMode == 2'h1 && cpuRun)
      else $error("main oscillator runs outside resonator mode");
   sub_run_a: assert property (subOscRun |-> subOscPinSel && cpuRun)
      else $error("sub oscillator runs without crystal pins");
   fast_clock_a: assert property (internalFastClockRun != internalReset)
      else $error("fast clock does not follow reset release");
   cpu_settle_a: assert property (cpuRun |-> settleCount >= SETTLE_WAIT - 1)
      else $error("cpu ran before settle time");
   sysclk_reset_a: assert property (internalReset [*2] |-> systemClockCtrl == 8'h09)
      else $error("system clock control not at reset value");
   fast_wait_a: assert property (fastIntOscSelect |-> fastCount >= FAST_WAIT - 1)
      else $error("fast select before wait elapsed");
   fast_avail_a: assert property ((intFreqOption == 2'h0) [*4] |-> !fastIntOscEnable)
      else $error("fast oscillator on with low option");
   det_hold_a: assert property ((detectorDefaultOn && !supplyAboveDetect) [*6] |-> internalReset)
      else $error("detector did not hold reset");
endmodule : clock_source_control_sva

bind clock_source_control clock_source_control_sva #(.FAST_WAIT(FAST_WAIT),
   .SETTLE_WAIT(SETTLE_WAIT)) clock_source_control_sva_inst (.*);

/* test/testbench.sv */
// self-checking bench for the clock source control block
`timescale 1ns/100ps
module testbench;
   localparam int FW = 20;
   logic clock, reset_n, psel, penable, pwrite, pready, pslverr, err, mainStable;
   logic supplyAboveClear, supplyAboveDetect, detectorDefaultOn, mainPinsArePorts;
   logic mainOscRun, extClockInputSel, mainFreqRange, subOscPinSel, subOscRun;
   logic internalReset, internalFastClockRun, cpuRun, fastIntOscEnable, fastIntOscSelect;
   logic [1:0] intFreqOption, mainPinMode, subDriveMode;
   logic [3:0] pstrb;
   logic [7:0] systemClockCtrl, v, w;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int mismatches = 0;
   int tests_run = 0;
   int seed = 32'h7431;
   int i, n;
   clock_source_control #(.FAST_WAIT(FW), .SETTLE_WAIT(20)) clock_source_control_inst (.*);
   osc_source_model osc_source_model_inst (.mainRun(mainOscRun), .subRun(subOscRun),
      .mainWave(), .subWave(), .mainStable(mainStable));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = !clock;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task timed_out;
      mismatches++;
      tally_and_finish();
   endtask : timed_out
   // one transfer; request held until pready is seen high
   task apb(input logic [19:0] a, input logic wr, input logic [7:0] d, input logic [3:0] s);
      int k;
      k = 0;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= {24'h000000, d};
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      if (k >= 50)
         timed_out();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task restart(input logic [1:0] opt);
      reset_n <= 1'b0;
      supplyAboveClear <= 1'b0;
      intFreqOption <= opt;
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      repeat (6) @(posedge clock);
      check("clear hold", internalReset, 1'b1);
      check("cpu held", cpuRun, 1'b0);
      supplyAboveClear <= 1'b1;
      for (n = 0; n < 500 && cpuRun !== 1'b1; n++) @(posedge clock);
      if (n >= 500)
         timed_out();
   endtask : restart
   function automatic logic [7:0] expect_mode(input logic [7:0] d);
      return d & clock_source_control_pkg::MODE_WRITABLE;
   endfunction : expect_mode
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      {psel, penable, pwrite, supplyAboveClear, detectorDefaultOn} = 5'h00;
      supplyAboveDetect = 1'b1;
      intFreqOption = 2'h1;
      paddr = 20'h00000;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
      @(posedge clock);
      for (i = 0; i < 4; i++) begin
         restart(i[1:0]);
         apb(20'hfffa8, 1'b0, 8'h00, 4'hf);
         check("clock ctrl reset", rd, 32'h09);
         v = 8'($random(seed));
         v[7:6] = i[1:0];
         v[2:1] = 2'(i % 3);
         v[0] = v[0] | (i == 1);
         if (i == 0) v = 8'h00;
         apb(20'hfffa0, 1'b1, ~v, 4'h2);
         apb(20'hfffa0, 1'b1, v, 4'hf);
         apb(20'hfffa0, 1'b1, ~v, 4'h1);
         apb(20'hfffa0, 1'b0, 8'h00, 4'hf);
         check("mode", rd, expect_mode(v));
         check("pin mode", mainPinMode, v[7:6]);
         check("ext clock", extClockInputSel, v[7] & v[6]);
         check("ports", mainPinsArePorts, !v[6]);
         check("sub pins", subOscPinSel, v[4]);
         check("drive", subDriveMode, v[2:1]);
         check("range", mainFreqRange, v[0]);
         check("main idle", mainOscRun, 1'b0);
         apb(20'hfffa4, 1'b1, 8'h00, 4'hf);
         check("main run", mainOscRun, v[7:6] == 2'h1);
         check("sub run", subOscRun, v[4]);
         for (n = 0; n < 100 && mainOscRun && !mainStable; n++) @(posedge clock);
         if (n >= 100)
            timed_out();
         w = 8'($random(seed));
         apb(20'hfffa8, 1'b1, w, 4'hf);
         check("clock ctrl", systemClockCtrl, w);
         apb(20'hfffac, 1'b1, 8'h03, 4'hf);
         check("select early", fastIntOscSelect, 1'b0);
         check("fast enable", fastIntOscEnable, i != 0);
         repeat (FW + 4) @(posedge clock);
         check("fast select", fastIntOscSelect, i != 0);
         apb(20'hfffb0, 1'b0, 8'h00, 4'hf);
         check("status", rd, {25'h0, i != 0, v[4], i == 1, i != 0, i != 0, 2'h3});
         apb(20'hfffbc, 1'b0, 8'h00, 4'hf);
         check("unmapped error", err, 1'b1);
         check("unmapped data", rd, 32'h0);
         $display("mode test %0d done", i);
      end
      detectorDefaultOn <= 1'b1;
      supplyAboveDetect <= 1'b0;
      repeat (8) @(posedge clock);
      check("detector hold", internalReset, 1'b1);
      supplyAboveDetect <= 1'b1;
      repeat (40) @(posedge clock);
      check("cpu after detect", cpuRun, 1'b1);
      check("clock ctrl cleared", systemClockCtrl, 8'h09);
      $display("detector test done");
      tally_and_finish();
   end
endmodule : testbench
